// *** ddc_pkg.sv ***
// ddc_pkg: register map, field layout and protocol constants of the direct coil drive
// assumes: a 7-bit register address space with one 32-bit word per address
package ddc_pkg;

	// register addresses
	localparam logic [6:0] REG_GLOBAL_CONFIG = 7'h00;
	localparam logic [6:0] REG_CURRENT       = 7'h10;
	localparam logic [6:0] REG_STANDSTILL    = 7'h11;
	localparam logic [6:0] REG_POSITION      = 7'h21;
	localparam logic [6:0] REG_SETPOINT      = 7'h2d;
	localparam logic [6:0] REG_CHOPPER       = 7'h6c;
	localparam logic [6:0] REG_PWM_CONFIG    = 7'h70;

	// global_config fields
	localparam int GC_PWM_MODE_BIT = 2;
	localparam int GC_DIRECT_BIT   = 16;

	// current register fields (standstill_current, motion_current, current_decay_delay)
	localparam int CUR_HOLD_LSB  = 0;
	localparam int CUR_RUN_LSB   = 8;
	localparam int CUR_DELAY_LSB = 16;
	localparam int CUR_W         = 5;
	localparam int DELAY_W       = 4;

	// standstill_wait and chopper_off_time fields
	localparam int WAIT_LSB = 0;
	localparam int WAIT_W   = 8;
	localparam int CHOPPER_OFF_TIME_LSB = 0;
	localparam int CHOPPER_OFF_TIME_W   = 4;

	// pwm configuration fields
	localparam int PWM_OFFSET_AMPLITUDE_LSB   = 0;
	localparam int PWM_VELOCITY_GRADIENT_LSB  = 8;
	localparam int PWM_AUTO_BIT  = 18;
	localparam int PWM_IDLE_LSB  = 20;
	localparam logic [1:0] IDLE_IDLE_COIL_OPTION = 2'b01;

	// setpoint fields: two signed 9-bit motor commands
	localparam int SETP_A_LSB = 0;
	localparam int SETP_B_LSB = 16;
	localparam int SETP_W     = 9;

	// reset values
	localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
	localparam logic [31:0] RST_PWM_CONF = 32'h0000_0000;
	localparam logic [7:0]  THROTTLE_MAX = 8'hff;

	// serial peripheral datagram
	localparam int SPI_FRAME_BITS = 40;
	localparam int SPI_WRITE_BIT  = 39;

	// single-wire datagram
	localparam logic [7:0] UART_SYNC      = 8'h05;
	localparam logic [7:0] UART_REPLY_DST = 8'hff;
	localparam logic [7:0] NODE_ADDR_HI   = 8'h01;
	localparam logic [7:0] NODE_ADDR_LO   = 8'h00;
	localparam logic [7:0] CRC_POLY       = 8'h07;
	localparam int         UART_WRITE_BIT = 7;
	localparam int         REPLY_BYTES    = 8;

	// run/hold timing: time base of the standstill and decay delays
	localparam int TICK_CYCLES_DEF = 262144;

endpackage

// *** ddc_uart_frame.sv ***
// ddc_uart_frame: single-wire datagram engine working on received and sent bytes
// assumes: a byte-level receiver/transmitter outside; host keeps one datagram at a time
`timescale 1ns/10ps
module ddc_uart_frame
	import ddc_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// received bytes
	input  wire logic [7:0]  rx_byte_i,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  node_addr_i,
	// register access
	output logic             wr_o,
	output logic [6:0]       addr_o,
	output logic [31:0]      data_o,
	input  wire logic [31:0] rd_data_i,
	// reply bytes
	output logic [7:0]       tx_byte_o,
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i
);

	typedef enum logic [2:0] {U_SYNC, U_NODE, U_ADDR, U_DATA, U_CRC, U_REPLY} ddc_ustate_t;

	ddc_ustate_t state_q;
	logic [7:0]  crc_q;
	logic [7:0]  tcrc_q;
	logic [2:0]  cnt_q;
	logic        is_wr_q;
	logic [47:0] reply_q;

	// one byte folded into the crc, least significant bit first
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[7] ^ b[i]) begin
				r = {r[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[6:0], 1'b0};
			end
		end
		return r;
	endfunction

	assign tx_valid_o = (state_q == U_REPLY);

	// datagram receive, check and reply sequence
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q   <= U_SYNC;
			crc_q     <= 8'h00;
			tcrc_q    <= 8'h00;
			cnt_q     <= 3'h0;
			is_wr_q   <= 1'b0;
			addr_o    <= 7'h00;
			data_o    <= RST_ZERO;
			wr_o      <= 1'b0;
			reply_q   <= 48'h0;
			tx_byte_o <= 8'h00;
		end else begin
			wr_o <= 1'b0;
			unique case (state_q)
				U_SYNC: if (rx_valid_i && rx_byte_i == UART_SYNC) begin
					crc_q   <= crc_step(8'h00, rx_byte_i);
					state_q <= U_NODE;
				end
				U_NODE: if (rx_valid_i) begin
					crc_q   <= crc_step(crc_q, rx_byte_i);
					state_q <= (rx_byte_i == node_addr_i) ? U_ADDR : U_SYNC;
				end
				U_ADDR: if (rx_valid_i) begin
					crc_q   <= crc_step(crc_q, rx_byte_i);
					addr_o  <= rx_byte_i[6:0];
					is_wr_q <= rx_byte_i[UART_WRITE_BIT];
					cnt_q   <= 3'h0;
					state_q <= rx_byte_i[UART_WRITE_BIT] ? U_DATA : U_CRC;
				end
				U_DATA: if (rx_valid_i) begin
					crc_q  <= crc_step(crc_q, rx_byte_i);
					data_o <= {data_o[23:0], rx_byte_i};
					cnt_q  <= cnt_q + 3'h1;
					if (cnt_q == 3'h3) begin
						state_q <= U_CRC;
					end
				end
				U_CRC: if (rx_valid_i) begin
					state_q <= U_SYNC;
					if (rx_byte_i == crc_q) begin
						if (is_wr_q) begin
							wr_o <= 1'b1;
						end else begin
							// eight-byte reply: sync, master, address, data, crc
							tx_byte_o <= UART_SYNC;
							tcrc_q    <= 8'h00;
							reply_q   <= {UART_REPLY_DST, 1'b0, addr_o, rd_data_i};
							cnt_q     <= 3'h0;
							state_q   <= U_REPLY;
						end
					end
				end
				U_REPLY: if (tx_ready_i) begin
					tcrc_q  <= crc_step(tcrc_q, tx_byte_o);
					cnt_q   <= cnt_q + 3'h1;
					reply_q <= {reply_q[39:0], 8'h00};
					if (cnt_q == 3'(REPLY_BYTES - 1)) begin
						state_q <= U_SYNC;
					end else if (cnt_q == 3'(REPLY_BYTES - 2)) begin
						tx_byte_o <= crc_step(tcrc_q, tx_byte_o);
					end else begin
						tx_byte_o <= reply_q[47:40];
					end
				end
				default: state_q <= U_SYNC;
			endcase
		end
	end

endmodule

// *** ddc_direct_drive.sv ***
// ddc_direct_drive: register file, serial access and direct coil drive of a two-coil driver
// assumes: all inputs synchronous to core_clk_i; bridges and current sensing sit outside
`timescale 1ns/10ps
// Overview of operation
// - direct flag takes coil commands from setpoint
// - setpoint 8..0 motor A, 24..16 motor B
// - direct current limit scaled by run/hold scale (hold setting at rest)
// - direct mode ignores step/dir positioning and ramp
// - 9-bit two's complement maps to +-100% voltage
// - pwm mode, autoscale off: no current sensing, duty only
// - hold zero plus option 01 freewheels coils
// - autoscale limit is run/hold scale times relative amplitude
// - regulate larger motor, scale other down too
// - chopper mode regulates each bridge independently
// - run/hold sequence runs, triggered by step only
// - step raises both coils to run, then hold
// - serial read returns data on next access
// - uart needs valid crc; node from select pin
// - uart write/read datagram layout, eight-byte reply
module ddc_direct_drive
	import ddc_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// serial peripheral port
	input  wire logic        spi_sck_i,
	input  wire logic        spi_csn_i,
	input  wire logic        spi_mosi_i,
	output logic             spi_miso_o,
	// single-wire port, byte level
	input  wire logic [7:0]  uart_rx_byte_i,
	input  wire logic        uart_rx_valid_i,
	input  wire logic        node_address_select_i,
	output logic [7:0]       uart_tx_byte_o,
	output logic             uart_tx_valid_o,
	input  wire logic        uart_tx_ready_i,
	// step/direction and motion-path coil commands
	input  wire logic        step_i,
	input  wire logic        dir_i,
	input  wire logic [8:0]  motion_coil_a_i,
	input  wire logic [8:0]  motion_coil_b_i,
	// current sense comparators
	input  wire logic        coil_a_over_i,
	input  wire logic        coil_b_over_i,
	// coil drive
	output logic             bridge_en_o,
	output logic [7:0]       coil_a_duty_o,
	output logic             coil_a_neg_o,
	output logic [7:0]       coil_b_duty_o,
	output logic             coil_b_neg_o,
	output logic [4:0]       coil_a_limit_o,
	output logic [4:0]       coil_b_limit_o,
	output logic             coil_a_reg_o,
	output logic             coil_b_reg_o,
	output logic             idle_coil_option_o,
	// motion controller side
	output logic             direct_active_o,
	output logic [31:0]      target_position_o
);

	typedef enum logic [1:0] {S_HOLD, S_RUN, S_WAIT, S_DECAY} ddc_cstate_t;

	logic [31:0] global_config_q, current_q, standstill_q, position_q;
	logic [31:0] direct_drive_setpoint_q, chopper_q, pwm_config_q;
	logic        direct, pwm_mode, autoscale;
	logic [4:0]  standstill_current, motion_current;
	logic [3:0]  current_decay_delay, chopper_off_time;
	logic [7:0]  standstill_wait;
	logic [1:0]  idle_coil_option;

	assign direct              = global_config_q[GC_DIRECT_BIT];
	assign pwm_mode            = global_config_q[GC_PWM_MODE_BIT];
	assign autoscale           = pwm_config_q[PWM_AUTO_BIT];
	assign idle_coil_option    = pwm_config_q[PWM_IDLE_LSB +: 2];
	assign standstill_current  = current_q[CUR_HOLD_LSB +: CUR_W];
	assign motion_current      = current_q[CUR_RUN_LSB +: CUR_W];
	assign current_decay_delay = current_q[CUR_DELAY_LSB +: DELAY_W];
	assign standstill_wait     = standstill_q[WAIT_LSB +: WAIT_W];
	assign chopper_off_time    = chopper_q[CHOPPER_OFF_TIME_LSB +: CHOPPER_OFF_TIME_W];

	// register read multiplexer shared by both ports
	function automatic logic [31:0] rd_mux(input logic [6:0] a);
		unique case (a)
			REG_GLOBAL_CONFIG: return global_config_q;
			REG_CURRENT:       return current_q;
			REG_STANDSTILL:    return standstill_q;
			REG_POSITION:      return position_q;
			REG_SETPOINT:      return direct_drive_setpoint_q;
			REG_CHOPPER:       return chopper_q;
			REG_PWM_CONFIG:    return pwm_config_q;
			default:           return RST_ZERO;
		endcase
	endfunction

	// serial peripheral: sck edges found against the previous sample
	logic        sck_q, csn_q, spi_wr, spi_end;
	logic [5:0]  bit_cnt_q;
	logic [39:0] rx_q, tx_q;
	logic [31:0] rd_latch_q;
	logic        sck_rise, sck_fall;

	assign sck_rise   = spi_sck_i & ~sck_q & ~spi_csn_i;
	assign sck_fall   = ~spi_sck_i & sck_q & ~spi_csn_i;
	assign spi_end    = spi_csn_i & ~csn_q & (bit_cnt_q == 6'(SPI_FRAME_BITS));
	assign spi_wr     = spi_end & rx_q[SPI_WRITE_BIT];
	assign spi_miso_o = tx_q[SPI_FRAME_BITS-1];

	// 40-bit shift in on rising sck, shift out on falling sck
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sck_q      <= 1'b0;
			csn_q      <= 1'b1;
			bit_cnt_q  <= 6'h00;
			rx_q       <= 40'h0;
			tx_q       <= 40'h0;
			rd_latch_q <= RST_ZERO;
		end else begin
			sck_q <= spi_sck_i;
			csn_q <= spi_csn_i;
			if (!spi_csn_i && csn_q) begin
				bit_cnt_q <= 6'h00;
				tx_q      <= {direct, 7'h00, rd_latch_q};
			end else if (sck_rise) begin
				rx_q <= {rx_q[38:0], spi_mosi_i};
				if (bit_cnt_q != 6'(SPI_FRAME_BITS)) begin
					bit_cnt_q <= bit_cnt_q + 6'h01;
				end
			end else if (sck_fall) begin
				tx_q <= {tx_q[38:0], 1'b0};
			end
			// named register is captured now and shifted out next access
			if (spi_end) begin
				rd_latch_q <= rd_mux(rx_q[38:32]);
			end
		end
	end

	// single-wire datagram engine
	logic        u_wr;
	logic [6:0]  u_addr;
	logic [31:0] u_data;

	ddc_uart_frame u_frame (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.rx_byte_i  (uart_rx_byte_i),
		.rx_valid_i (uart_rx_valid_i),
		.node_addr_i(node_address_select_i ? NODE_ADDR_HI : NODE_ADDR_LO),
		.wr_o       (u_wr),
		.addr_o     (u_addr),
		.data_o     (u_data),
		.rd_data_i  (rd_mux(u_addr)),
		.tx_byte_o  (uart_tx_byte_o),
		.tx_valid_o (uart_tx_valid_o),
		.tx_ready_i (uart_tx_ready_i)
	);

	// one write port: serial peripheral wins a same-cycle clash
	logic        wr_en;
	logic [6:0]  wr_addr;
	logic [31:0] wr_data;

	assign wr_en   = spi_wr | u_wr;
	assign wr_addr = spi_wr ? rx_q[38:32] : u_addr;
	assign wr_data = spi_wr ? rx_q[31:0] : u_data;

	// configuration registers
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			global_config_q         <= RST_ZERO;
			current_q               <= RST_ZERO;
			standstill_q            <= RST_ZERO;
			direct_drive_setpoint_q <= RST_ZERO;
			chopper_q               <= RST_ZERO;
			pwm_config_q            <= RST_PWM_CONF;
		end else if (wr_en) begin
			unique case (wr_addr)
				REG_GLOBAL_CONFIG: global_config_q <= wr_data;
				REG_CURRENT:       current_q <= wr_data;
				REG_STANDSTILL:    standstill_q <= wr_data;
				REG_SETPOINT:      direct_drive_setpoint_q <= wr_data;
				REG_CHOPPER:       chopper_q <= wr_data;
				REG_PWM_CONFIG:    pwm_config_q <= wr_data;
				default:           ;
			endcase
		end
	end

	// step edge detect
	logic step_q, step_rise;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			step_q <= 1'b0;
		end else begin
			step_q <= step_i;
		end
	end
	assign step_rise = step_i & ~step_q;

	// position counter: step/dir only outside direct mode
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			position_q <= RST_ZERO;
		end else if (wr_en && wr_addr == REG_POSITION) begin
			position_q <= wr_data;
		end else if (step_rise && !direct) begin
			position_q <= dir_i ? position_q + 32'h1 : position_q - 32'h1;
		end
	end

	assign direct_active_o   = direct;
	assign target_position_o = direct_drive_setpoint_q;

	// run/hold current sequencer on a common time base
	ddc_cstate_t cstate_q;
	logic [4:0]  scale_q, cur_scale;
	logic [7:0]  tcnt_q;
	logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_q;
	logic        tick;

	assign tick      = (tick_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
	assign cur_scale = (cstate_q == S_HOLD) ? standstill_current : scale_q;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cstate_q <= S_HOLD;
			scale_q  <= 5'h00;
			tcnt_q   <= 8'h00;
		end else if (step_rise) begin
			cstate_q <= S_RUN;
			scale_q  <= motion_current;
			tcnt_q   <= 8'h00;
		end else begin
			unique case (cstate_q)
				S_HOLD:  ;
				S_RUN:   cstate_q <= S_WAIT;
				S_WAIT: if (tick) begin
					tcnt_q <= tcnt_q + 8'h01;
					if (tcnt_q >= standstill_wait) begin
						tcnt_q   <= 8'h00;
						cstate_q <= S_DECAY;
					end
				end
				S_DECAY: if (scale_q <= standstill_current) begin
					cstate_q <= S_HOLD;
				end else if (tick) begin
					tcnt_q <= tcnt_q + 8'h01;
					if (tcnt_q[3:0] >= current_decay_delay) begin
						tcnt_q  <= 8'h00;
						scale_q <= scale_q - 5'h01;
					end
				end
			endcase
		end
	end

	// coil command source and magnitude
	logic [8:0] cmd_a, cmd_b, mag_a9, mag_b9;
	logic [7:0] mag_a, mag_b;
	logic       a_dom;

	assign cmd_a  = direct ? direct_drive_setpoint_q[SETP_A_LSB +: SETP_W]
		: motion_coil_a_i;
	assign cmd_b  = direct ? direct_drive_setpoint_q[SETP_B_LSB +: SETP_W]
		: motion_coil_b_i;
	assign mag_a9 = cmd_a[8] ? (~cmd_a + 9'h001) : cmd_a;
	assign mag_b9 = cmd_b[8] ? (~cmd_b + 9'h001) : cmd_b;
	assign mag_a  = mag_a9[8] ? 8'hff : mag_a9[7:0];
	assign mag_b  = mag_b9[8] ? 8'hff : mag_b9[7:0];
	assign a_dom  = (mag_a >= mag_b);

	// shared pwm throttle: backs off while the dominant motor is over its limit
	logic [7:0] thr_q;
	logic       regulate, dom_over;

	assign regulate = pwm_mode & autoscale;
	assign dom_over = a_dom ? coil_a_over_i : coil_b_over_i;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			thr_q <= THROTTLE_MAX;
		end else if (!regulate) begin
			thr_q <= THROTTLE_MAX;
		end else if (dom_over) begin
			thr_q <= (thr_q == 8'h00) ? thr_q : thr_q - 8'h01;
		end else begin
			thr_q <= (thr_q == THROTTLE_MAX) ? thr_q : thr_q + 8'h01;
		end
	end

	// scaled duty and current limits
	logic [16:0] duty_a_p, duty_b_p;
	logic [12:0] lim_a_p, lim_b_p;

	assign duty_a_p = mag_a * {1'b0, thr_q} + mag_a;
	assign duty_b_p = mag_b * {1'b0, thr_q} + mag_b;
	assign lim_a_p  = cur_scale * mag_a;
	assign lim_b_p  = cur_scale * mag_b;

	// registered coil drive outputs
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			coil_a_duty_o  <= 8'h00;
			coil_b_duty_o  <= 8'h00;
			coil_a_neg_o   <= 1'b0;
			coil_b_neg_o   <= 1'b0;
			coil_a_limit_o <= 5'h00;
			coil_b_limit_o <= 5'h00;
			coil_a_reg_o   <= 1'b0;
			coil_b_reg_o   <= 1'b0;
			idle_coil_option_o    <= 1'b0;
			bridge_en_o    <= 1'b0;
		end else begin
			coil_a_duty_o <= duty_a_p[15:8];
			coil_b_duty_o <= duty_b_p[15:8];
			coil_a_neg_o  <= cmd_a[8];
			coil_b_neg_o  <= cmd_b[8];
			bridge_en_o   <= (chopper_off_time != 4'h0);
			idle_coil_option_o   <= (standstill_current == 5'h00)
				&& (idle_coil_option == IDLE_IDLE_COIL_OPTION);
			if (!pwm_mode) begin
				coil_a_limit_o <= cur_scale;
				coil_b_limit_o <= cur_scale;
				coil_a_reg_o   <= 1'b1;
				coil_b_reg_o   <= 1'b1;
			end else if (autoscale) begin
				coil_a_limit_o <= lim_a_p[12:8];
				coil_b_limit_o <= lim_b_p[12:8];
				coil_a_reg_o   <= a_dom;
				coil_b_reg_o   <= ~a_dom;
			end else begin
				coil_a_limit_o <= cur_scale;
				coil_b_limit_o <= cur_scale;
				coil_a_reg_o   <= 1'b0;
				coil_b_reg_o   <= 1'b0;
			end
		end
	end

	// checks
	a_step_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i)
		direct && step_rise && !wr_en |=> position_q == $past(position_q))
		else $error("step moved position in direct mode");
	a_step_counts: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!direct && step_rise && dir_i && !wr_en |=> position_q == $past(position_q) + 32'h1)
		else $error("step did not advance position");
	a_polarity_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		direct |=> coil_a_neg_o == $past(direct_drive_setpoint_q[8]))
		else $error("coil a polarity not from setpoint");
	a_polarity_b: assert property (@(posedge core_clk_i) disable iff (rst_i)
		direct |=> coil_b_neg_o == $past(direct_drive_setpoint_q[24]))
		else $error("coil b polarity not from setpoint");
	a_run_on_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
		step_rise |=> cstate_q == S_RUN && scale_q == $past(motion_current) ##1 cstate_q == S_WAIT)
		else $error("step did not start run current");
	a_voltage_nosense: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pwm_mode && !autoscale |=> !coil_a_reg_o && !coil_b_reg_o && thr_q == THROTTLE_MAX)
		else $error("sensing used with autoscale off");
	a_chop_indep: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!pwm_mode |=> coil_a_reg_o && coil_b_reg_o && coil_a_limit_o == coil_b_limit_o)
		else $error("chopper mode not regulating both bridges");
	a_dominant_reg: assert property (@(posedge core_clk_i) disable iff (rst_i)
		regulate && mag_a > mag_b |=> coil_a_reg_o && !coil_b_reg_o)
		else $error("regulation not on larger motor");
	a_idle_coil_option_cond: assert property (@(posedge core_clk_i) disable iff (rst_i)
		idle_coil_option_o |-> $past(standstill_current) == 5'h00)
		else $error("idle_coil_option with nonzero hold current");
	a_spi_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
		spi_wr && rx_q[38:32] == REG_SETPOINT |=> direct_drive_setpoint_q == $past(rx_q[31:0]))
		else $error("serial write lost");

endmodule

// *** ddc_bridge_model.sv ***
// ddc_bridge_model: two power bridges with coils and their over-current comparators
// assumes: duty and limit come straight from the block under test
`timescale 1ns/10ps
module ddc_bridge_model (
	// coil drive from the block
	input  wire logic       bridge_en_i,
	input  wire logic [7:0] duty_a_i,
	input  wire logic [7:0] duty_b_i,
	input  wire logic [4:0] limit_a_i,
	input  wire logic [4:0] limit_b_i,
	// sense comparators back to the block
	output logic            over_a_o,
	output logic            over_b_o
);
	// coil current settles with duty; the comparator trips above the limit
	assign over_a_o = bridge_en_i && (duty_a_i[7:3] > limit_a_i);
	assign over_b_o = bridge_en_i && (duty_b_i[7:3] > limit_b_i);
endmodule

// *** testbench.sv ***
// testbench: register traffic over both serial ports and checks of the coil drive
// assumes: bridge model on the coil side, delay tick shortened to four cycles
`timescale 1ns/10ps
module testbench;
	import ddc_pkg::*;
	localparam int TICKS = 4;
	logic        core_clk_i, rst_i, sck, csn, mosi, miso, rx_valid, nsel;
	logic        tx_valid, tx_ready, step, dir, over_a, over_b, bridge_en, neg_a, neg_b;
	logic        reg_a, reg_b, fw, dact;
	logic [7:0]  rx_byte, tx_byte, duty_a, duty_b;
	logic [8:0]  mot_a, mot_b, va, vb;
	logic [4:0]  lim_a, lim_b;
	logic [31:0] tgt, d, p;
	logic [39:0] r;
	logic [63:0] u;
	int          seed, miscompares, checks_done;

	ddc_direct_drive #(.TICK_CYCLES(TICKS)) i_ddc_direct_drive (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .spi_sck_i(sck), .spi_csn_i(csn), .spi_mosi_i(mosi),
		.spi_miso_o(miso), .uart_rx_byte_i(rx_byte), .uart_rx_valid_i(rx_valid),
		.node_address_select_i(nsel), .uart_tx_byte_o(tx_byte), .uart_tx_valid_o(tx_valid),
		.uart_tx_ready_i(tx_ready), .step_i(step), .dir_i(dir), .motion_coil_a_i(mot_a),
		.motion_coil_b_i(mot_b), .coil_a_over_i(over_a), .coil_b_over_i(over_b),
		.bridge_en_o(bridge_en), .coil_a_duty_o(duty_a), .coil_a_neg_o(neg_a),
		.coil_b_duty_o(duty_b), .coil_b_neg_o(neg_b), .coil_a_limit_o(lim_a),
		.coil_b_limit_o(lim_b), .coil_a_reg_o(reg_a), .coil_b_reg_o(reg_b),
		.idle_coil_option_o(fw), .direct_active_o(dact), .target_position_o(tgt));
	ddc_bridge_model i_ddc_bridge_model (.bridge_en_i(bridge_en), .duty_a_i(duty_a),
		.duty_b_i(duty_b), .limit_a_i(lim_a), .limit_b_i(lim_b), .over_a_o(over_a),
		.over_b_o(over_b));

	// free-running core clock
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic wrap_up();
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	// one 40-bit frame, miso taken just before each sck rise
	task automatic spi(input logic [39:0] tx, output logic [39:0] rx);
		csn = 1'b0;
		cyc(2);
		for (int i = 39; i >= 0; i--) begin
			mosi = tx[i];
			cyc(2);
			rx[i] = miso;
			sck = 1'b1;
			cyc(2);
			sck = 1'b0;
		end
		cyc(2);
		csn = 1'b1;
		cyc(4);
	endtask

	task automatic wr(input logic [6:0] a, input logic [31:0] v);
		logic [39:0] x;
		spi({1'b1, a, v}, x);
	endtask

	// split-phase read: the second frame carries the answer
	task automatic rd(input logic [6:0] a, output logic [39:0] x);
		spi({1'b0, a, 32'h0000_0000}, x);
		spi({1'b0, a, 32'h0000_0000}, x);
	endtask

	function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
		logic [7:0] c, b;
		c = 8'h00;
		for (int k = n - 1; k >= 0; k--) begin
			b = v[8*k +: 8];
			for (int i = 0; i < 8; i++) begin
				c = (c[7] ^ b[0]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
				b = b >> 1;
			end
		end
		return c;
	endfunction

	function automatic logic [7:0] mag(input logic [8:0] v);
		return v[8] ? ((v == 9'h100) ? 8'hff : 8'(-v)) : v[7:0];
	endfunction

	// n payload bytes, then crc with an optional corruption mask
	task automatic usend(input logic [63:0] v, input int n, input logic [7:0] flip);
		for (int k = n; k >= 0; k--) begin
			rx_byte = (k == 0) ? (crc8(v, n) ^ flip) : v[8*(k-1) +: 8];
			rx_valid = 1'b1;
			cyc(1);
			rx_valid = 1'b0;
			cyc(1);
		end
		cyc(3);
	endtask

	// reply stalls until the bench opens tx_ready
	task automatic ureply(output logic [63:0] x);
		tx_ready = 1'b1;
		for (int k = 7; k >= 0; k--) begin
			for (int w = 0; w < 20 && tx_valid !== 1'b1; w++) cyc(1);
			x[8*k +: 8] = tx_byte;
			cyc(1);
		end
		tx_ready = 1'b0;
	endtask

	// hang guard
	initial begin
		#400us;
		miscompares++;
		wrap_up();
	end

	// main sequence
	initial begin
		{sck, mosi, rx_valid, tx_ready, step, dir, rx_byte, mot_a, mot_b} = '0;
		{csn, nsel, rst_i} = 3'b111;
		seed = 94;
		miscompares = 0;
		checks_done = 0;
		cyc(5);
		rst_i = 1'b0;
		cyc(1);
		chk({reg_a, reg_b, dact, bridge_en, tgt}, {2'b11, 34'h0});
		wr(REG_PWM_CONFIG, 32'h0010_04ff);
		wr(REG_CURRENT, 32'h0000_1400);
		chk(fw, 1);
		wr(REG_CHOPPER, 32'h0000_0003);
		chk(bridge_en, 1);
		wr(REG_CURRENT, 32'h0000_1405);
		chk(fw, 0);
		wr(REG_STANDSTILL, 32'h0000_0002);
		wr(REG_GLOBAL_CONFIG, 32'h0001_0004);
		chk(dact, 1);
		chk(lim_a === 5'd20, 0);
		for (int i = 0; i < 10; i++) begin
			va = (i == 0) ? 9'h0ff : (i == 1) ? 9'h101 : (i == 2) ? 9'h100 : 9'($random(seed));
			vb = 9'($random(seed));
			mot_a = 9'($random(seed));
			mot_b = 9'($random(seed));
			dir = 1'($random(seed));
			wr(REG_SETPOINT, {7'h00, vb, 7'h00, va});
			chk({neg_a, duty_a}, {va[8], mag(va)});
			chk({neg_b, duty_b}, {vb[8], mag(vb)});
		end
		step = 1'b1;
		cyc(3);
		chk({lim_a, lim_b}, {5'd20, 5'd20});
		step = 1'b0;
		cyc(300);
		chk({lim_a, lim_b}, {5'd5, 5'd5});
		// autoscale: motor a dominant, throttle settles at its limit
		wr(REG_PWM_CONFIG, 32'h0014_001e);
		wr(REG_SETPOINT, 32'h0040_0080);
		cyc(300);
		chk({reg_a, reg_b, lim_a, lim_b}, {2'b10, 5'd2, 5'd1});
		chk(duty_a[7:4], 4'h1);
		chk(duty_b, {1'b0, duty_a[7:1]});
		wr(REG_PWM_CONFIG, 32'h0010_04ff);
		p = $random(seed);
		wr(REG_POSITION, p);
		rd(REG_POSITION, r);
		chk({r[39], r[31:0]}, {1'b1, p});
		rd(7'h7f, r);
		chk(r[31:0], 0);
		d = $random(seed);
		usend({8'h05, NODE_ADDR_HI, 1'b1, REG_SETPOINT, d}, 7, 8'h00);
		chk(tgt, d);
		usend({8'h05, NODE_ADDR_HI, 1'b1, REG_SETPOINT, ~d}, 7, 8'h01);
		usend({8'h05, NODE_ADDR_LO, 1'b1, REG_SETPOINT, ~d}, 7, 8'h00);
		chk(tgt, d);
		usend({8'h05, NODE_ADDR_HI, 1'b0, REG_POSITION}, 3, 8'h00);
		chk(tx_valid, 1);
		ureply(u);
		chk({tx_valid, u[63:40]}, {1'b0, UART_SYNC, UART_REPLY_DST, 1'b0, REG_POSITION});
		chk(u[39:8], p);
		chk(u[7:0], crc8(u >> 8, 7));
		wr(REG_GLOBAL_CONFIG, 32'h0000_0004);
		chk({dact, neg_a, duty_a}, {1'b0, mot_a[8], mag(mot_a)});
		// with the flag clear a step moves the position again
		dir = 1'b1;
		step = 1'b1;
		cyc(2);
		step = 1'b0;
		rd(REG_POSITION, r);
		chk({r[39], r[31:0]}, {1'b0, p + 32'h1});
		wrap_up();
	end
endmodule
